//--- rtl/wrf_pkg.sv
// Shared constants and types for the watchdog and reset-cause block
package wrf_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_FREQ_HZ = 40_000_000;
  localparam int unsigned OSC_FREQ_HZ = 1_000_000;
  localparam int unsigned OSC_DIV = CLK_FREQ_HZ / OSC_FREQ_HZ;
  localparam int unsigned BASE_TIMEOUT_TICKS = 16384;
  localparam int unsigned CE_HOLD_CYCLES = 4;

  // ****************************************
  // Register map
  // ****************************************
  localparam int unsigned ADDR_W = 2;
  localparam logic [ADDR_W-1:0] ADDR_RESET_CAUSE = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_WDT_CTRL = 2'h1;

  localparam int unsigned FLAG_POWER_ON = 0;
  localparam int unsigned FLAG_EXTERNAL = 1;
  localparam int unsigned FLAG_BROWNOUT = 2;
  localparam int unsigned FLAG_WATCHDOG = 3;
  localparam int unsigned FLAG_TEST_PORT = 4;
  localparam int unsigned FLAG_COUNT = 5;
  localparam logic [FLAG_COUNT-1:0] CAUSE_RESET = 5'h01;

  localparam int unsigned CTRL_CHANGE_ENABLE = 4;
  localparam int unsigned CTRL_WDT_ENABLE = 3;
  localparam int unsigned CTRL_PRESC_LSB = 0;
  localparam int unsigned PRESC_W = 3;
  localparam logic [PRESC_W-1:0] PRESC_RESET = 3'h0;
  localparam logic [2:0] CE_CNT_RESET = 3'h0;

  // ****************************************
  // Types
  // ****************************************
  typedef logic [PRESC_W-1:0] wrf_presc_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } wrf_bus_req_s;

  typedef struct packed {
    logic testPortReset;
    logic brownoutReset;
    logic extReset_n;
    logic alwaysOnFuse;
  } wrf_async_s;

  localparam logic [3:0] SYNC_RESET = 4'h2;

endpackage : wrf_pkg

//--- rtl/wrf_timeout_counter.sv
// Watchdog oscillator tick divider and time-out counter
`timescale 1ns/1ps
module wrf_timeout_counter #(
  parameter int unsigned DIV = wrf_pkg::OSC_DIV,
  parameter int unsigned BASE_TICKS = wrf_pkg::BASE_TIMEOUT_TICKS
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic restart,
  input wire logic enable,
  input wire wrf_pkg::wrf_presc_t presc,
  output logic expire
);
  import wrf_pkg::*;

  localparam int unsigned DIV_W = $clog2(DIV);
  localparam int unsigned CNT_W = $clog2(BASE_TICKS) + 8;

  if (DIV < 2) begin : g_bad_div
    $error("Divider must be at least two");
  end
  if (BASE_TICKS < 2) begin : g_bad_base
    $error("Base time-out must be at least two ticks");
  end

  logic [DIV_W-1:0] divCnt_r;
  logic [DIV_W-1:0] divCnt_nxt;
  logic [CNT_W-1:0] tickCnt_r;
  logic [CNT_W-1:0] tickCnt_nxt;
  logic expire_r;
  logic expire_nxt;
  logic tick;
  logic [CNT_W-1:0] limit;

  // ****************************************
  // Oscillator tick and count
  // ****************************************
  always_comb begin
    tick = (divCnt_r == DIV_W'(DIV - 1));
    divCnt_nxt = tick ? '0 : divCnt_r + 1'b1;
    limit = CNT_W'(BASE_TICKS) << presc;
    expire_nxt = 1'b0;
    tickCnt_nxt = tickCnt_r;
    if (restart || !enable) begin
      tickCnt_nxt = '0;
    end else if (tick) begin
      if (tickCnt_r == limit - 1'b1) begin
        tickCnt_nxt = '0;
        expire_nxt = 1'b1;
      end else begin
        tickCnt_nxt = tickCnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      divCnt_r <= '0;
      tickCnt_r <= '0;
      expire_r <= 1'b0;
    end else begin
      divCnt_r <= divCnt_nxt;
      tickCnt_r <= tickCnt_nxt;
      expire_r <= expire_nxt;
    end
  end

  assign expire = expire_r;

  // ****************************************
  // Checks
  // ****************************************
  a_restart_clears: assert property (@(posedge clk_sys) disable iff (rst)
    (restart || !enable) |=> (tickCnt_r == '0))
    else $error("Count not restarted");
  a_expire_at_limit: assert property (@(posedge clk_sys) disable iff (rst)
    expire_r |-> ($past(tickCnt_r) == $past(limit) - 1'b1))
    else $error("Expiry away from selected limit");

endmodule : wrf_timeout_counter

//--- rtl/wrf_watchdog_top.sv
// Watchdog timer with protected changes and reset-cause flags
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module wrf_watchdog_top #(
  parameter int unsigned DIV = wrf_pkg::OSC_DIV,
  parameter int unsigned BASE_TICKS = wrf_pkg::BASE_TIMEOUT_TICKS
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire wrf_pkg::wrf_bus_req_s busReq,
  output logic [7:0] rdata,
  input wire wrf_pkg::wrf_async_s asyncIn,
  input wire logic wdtRestartReq,
  output logic wdtResetPulse,
  output logic chipResetReq
);
  import wrf_pkg::*;

  if (CE_HOLD_CYCLES < 1 || CE_HOLD_CYCLES > 7) begin : g_bad_hold
    $error("Change-enable hold does not fit its counter");
  end

  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [FLAG_COUNT-1:0] flags_r;
  logic [FLAG_COUNT-1:0] flags_nxt;
  logic [FLAG_COUNT-1:0] flagSet;
  logic [2:0] ceCnt_r;
  logic [2:0] ceCnt_nxt;
  logic wde_r;
  logic wde_nxt;
  wrf_presc_t presc_r;
  wrf_presc_t presc_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic wrCause;
  logic wrCtrl;
  logic unlock;
  logic ceActive;
  logic level2;
  logic always_on_fuse;
  logic expire;
  logic extRst;
  logic borRst;
  logic tpRst;
  logic chipRst;
  logic [7:0] causeRead;
  logic [7:0] ctrlRead;

  // ****************************************
  // Input synchronisers
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_r <= SYNC_RESET;
      sync2_r <= SYNC_RESET;
    end else begin
      sync1_r <= asyncIn;
      sync2_r <= sync1_r;
    end
  end

  always_comb begin
    tpRst = sync2_r[3];
    borRst = sync2_r[2];
    extRst = !sync2_r[1];
    level2 = sync2_r[0];
    chipRst = expire || extRst || borRst || tpRst;
    wrCause = busReq.wr && (busReq.addr == ADDR_RESET_CAUSE);
    wrCtrl = busReq.wr && (busReq.addr == ADDR_WDT_CTRL);
    unlock = wrCtrl && busReq.wdata[CTRL_CHANGE_ENABLE] && busReq.wdata[CTRL_WDT_ENABLE];
    ceActive = (ceCnt_r != 3'h0);
    always_on_fuse = wde_r || level2;
  end

  // ****************************************
  // Reset-cause flags
  // ****************************************
  always_comb begin
    flagSet = '0;
    flagSet[FLAG_EXTERNAL] = extRst;
    flagSet[FLAG_BROWNOUT] = borRst;
    flagSet[FLAG_WATCHDOG] = expire;
    flagSet[FLAG_TEST_PORT] = tpRst;
    flags_nxt = flags_r;
    for (int i = 0; i < FLAG_COUNT; i++) begin
      // Clear only on written zero, set wins over clear
      if (wrCause && !busReq.wdata[i]) begin
        flags_nxt[i] = 1'b0;
      end
      if (flagSet[i]) begin
        flags_nxt[i] = 1'b1;
      end
    end
  end

  // Reset is power-on: it clears causes and sets the power-on flag
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flags_r <= CAUSE_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ****************************************
  // Watchdog control
  // ****************************************
  always_comb begin
    ceCnt_nxt = ceActive ? ceCnt_r - 3'h1 : 3'h0;
    wde_nxt = wde_r;
    presc_nxt = presc_r;
    if (unlock) begin
      ceCnt_nxt = 3'(CE_HOLD_CYCLES);
    end
    if (wrCtrl) begin
      if (busReq.wdata[CTRL_WDT_ENABLE]) begin
        wde_nxt = 1'b1;
      end else if (ceActive) begin
        wde_nxt = 1'b0;
      end
      if (ceActive) begin
        presc_nxt = busReq.wdata[CTRL_PRESC_LSB +: PRESC_W];
      end
    end
    if (chipRst) begin
      ceCnt_nxt = CE_CNT_RESET;
      wde_nxt = 1'b0;
      presc_nxt = PRESC_RESET;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ceCnt_r <= CE_CNT_RESET;
      wde_r <= 1'b0;
      presc_r <= PRESC_RESET;
    end else begin
      ceCnt_r <= ceCnt_nxt;
      wde_r <= wde_nxt;
      presc_r <= presc_nxt;
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  always_comb begin
    causeRead = 8'h00;
    causeRead[FLAG_COUNT-1:0] = flags_r;
    ctrlRead = 8'h00;
    ctrlRead[CTRL_CHANGE_ENABLE] = ceActive;
    ctrlRead[CTRL_WDT_ENABLE] = always_on_fuse;
    ctrlRead[CTRL_PRESC_LSB +: PRESC_W] = presc_r;
    rdata_nxt = 8'h00;
    if (busReq.rd) begin
      case (busReq.addr)
        ADDR_RESET_CAUSE: rdata_nxt = causeRead;
        ADDR_WDT_CTRL: rdata_nxt = ctrlRead;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;

  // ****************************************
  // Time-out counter
  // ****************************************
  wrf_timeout_counter #(
    .DIV(DIV),
    .BASE_TICKS(BASE_TICKS)
  ) u_counter (
    .clk_sys(clk_sys),
    .rst(rst),
    .restart(wdtRestartReq || chipRst),
    .enable(always_on_fuse),
    .presc(presc_r),
    .expire(expire)
  );

  assign wdtResetPulse = expire;
  assign chipResetReq = chipRst;

  // ****************************************
  // Checks
  // ****************************************
  a_ce_self_clear: assert property (@(posedge clk_sys) disable iff (rst)
    unlock ##1 (!unlock)[*4] |=> !ceActive)
    else $error("Change-enable did not clear after four cycles");
  a_ce_held: assert property (@(posedge clk_sys) disable iff (rst)
    (unlock && !chipRst) ##1 (!chipRst)[*3] |=> ceActive)
    else $error("Change-enable dropped early");
  a_wde_guarded: assert property (@(posedge clk_sys) disable iff (rst)
    (wrCtrl && !busReq.wdata[CTRL_WDT_ENABLE] && !ceActive && wde_r && !chipRst) |=> wde_r)
    else $error("Enable cleared without change-enable");
  a_presc_locked: assert property (@(posedge clk_sys) disable iff (rst)
    (!ceActive && !chipRst) |=> $stable(presc_r))
    else $error("Prescaler changed while locked");
  a_wde_set_free: assert property (@(posedge clk_sys) disable iff (rst)
    (wrCtrl && busReq.wdata[CTRL_WDT_ENABLE] && !chipRst) |=> wde_r)
    else $error("Enable write ignored");
  a_level2_on: assert property (@(posedge clk_sys) disable iff (rst)
    level2 |-> always_on_fuse)
    else $error("Watchdog off at safety level two");
  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (rst)
    (busReq.rd && busReq.addr == ADDR_WDT_CTRL) |=> (rdata[7:5] == 3'h0))
    else $error("Reserved control bits read nonzero");
  a_wde_reads_one: assert property (@(posedge clk_sys) disable iff (rst)
    (busReq.rd && busReq.addr == ADDR_WDT_CTRL && level2) |=> rdata[CTRL_WDT_ENABLE])
    else $error("Enable read zero at safety level two");
  a_wd_flag_set: assert property (@(posedge clk_sys) disable iff (rst)
    wdtResetPulse |=> flags_r[FLAG_WATCHDOG])
    else $error("Watchdog flag not set");
  a_pulse_single: assert property (@(posedge clk_sys) disable iff (rst)
    wdtResetPulse |=> !wdtResetPulse)
    else $error("Reset pulse longer than one cycle");
  a_por_sticky: assert property (@(posedge clk_sys) disable iff (rst)
    (flags_r[FLAG_POWER_ON] && !(wrCause && !busReq.wdata[FLAG_POWER_ON]))
      |=> flags_r[FLAG_POWER_ON])
    else $error("Power-on flag lost");
  a_write_one_keeps: assert property (@(posedge clk_sys) disable iff (rst)
    (wrCause && busReq.wdata[FLAG_EXTERNAL] && !flags_r[FLAG_EXTERNAL] && !extRst)
      |=> !flags_r[FLAG_EXTERNAL])
    else $error("Writing one set a cause flag");
  a_ext_flag_set: assert property (@(posedge clk_sys) disable iff (rst)
    extRst |=> flags_r[FLAG_EXTERNAL])
    else $error("External flag not set");

  // ****************************************
  // Flag, control and counter checks
  // ****************************************
  a_tp_flag_set: assert property (@(posedge clk_sys) disable iff (rst)
    tpRst |=> flags_r[FLAG_TEST_PORT])
    else $error("Test-port flag not set");
  a_bor_flag_set: assert property (@(posedge clk_sys) disable iff (rst)
    borRst |=> flags_r[FLAG_BROWNOUT])
    else $error("Brown-out flag not set");
  a_tp_clear: assert property (@(posedge clk_sys) disable iff (rst)
    (wrCause && !busReq.wdata[FLAG_TEST_PORT] && !tpRst) |=> !flags_r[FLAG_TEST_PORT])
    else $error("Test-port flag not cleared");
  a_wd_clear: assert property (@(posedge clk_sys) disable iff (rst)
    (wrCause && !busReq.wdata[FLAG_WATCHDOG] && !expire) |=> !flags_r[FLAG_WATCHDOG])
    else $error("Watchdog flag not cleared");
  a_bor_clear: assert property (@(posedge clk_sys) disable iff (rst)
    (wrCause && !busReq.wdata[FLAG_BROWNOUT] && !borRst) |=> !flags_r[FLAG_BROWNOUT])
    else $error("Brown-out flag not cleared");
  a_ext_clear: assert property (@(posedge clk_sys) disable iff (rst)
    (wrCause && !busReq.wdata[FLAG_EXTERNAL] && !extRst) |=> !flags_r[FLAG_EXTERNAL])
    else $error("External flag not cleared");
  a_por_clear: assert property (@(posedge clk_sys) disable iff (rst)
    (wrCause && !busReq.wdata[FLAG_POWER_ON]) |=> !flags_r[FLAG_POWER_ON])
    else $error("Power-on flag not cleared");
  a_por_no_set: assert property (@(posedge clk_sys) disable iff (rst)
    !flags_r[FLAG_POWER_ON] |=> !flags_r[FLAG_POWER_ON])
    else $error("Power-on flag set without power-on");
  a_wde_disable: assert property (@(posedge clk_sys) disable iff (rst)
    (wrCtrl && !busReq.wdata[CTRL_WDT_ENABLE] && ceActive && !chipRst) |=> !wde_r)
    else $error("Unlocked disable ignored");
  a_ce_read: assert property (@(posedge clk_sys) disable iff (rst)
    (busReq.rd && busReq.addr == ADDR_WDT_CTRL) |=> (rdata[CTRL_CHANGE_ENABLE] == $past(ceActive)))
    else $error("Change-enable read wrong");
  a_presc_read: assert property (@(posedge clk_sys) disable iff (rst)
    (busReq.rd && busReq.addr == ADDR_WDT_CTRL) |=> (rdata[PRESC_W-1:0] == $past(presc_r)))
    else $error("Prescaler read wrong");
  a_chip_ctrl_init: assert property (@(posedge clk_sys) disable iff (rst)
    chipRst |=> (!wde_r && !ceActive && presc_r == PRESC_RESET))
    else $error("Chip reset left control set");
  a_chip_no_pulse: assert property (@(posedge clk_sys) disable iff (rst)
    chipRst |=> !wdtResetPulse)
    else $error("Time-out right after chip reset");
  a_pulse_needs_on: assert property (@(posedge clk_sys) disable iff (rst)
    wdtResetPulse |-> $past(always_on_fuse))
    else $error("Time-out while watchdog off");

endmodule : wrf_watchdog_top

//--- tb/tb_wrf_watchdog_top.sv
// Self-checking bench for the watchdog and reset-cause block
`timescale 1ns/1ps
module tb_wrf_watchdog_top;
  import wrf_pkg::*;
  localparam int unsigned TDIV = 2;
  localparam int unsigned TBASE = 4;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  wrf_bus_req_s busReq = '0;
  wrf_async_s asyncIn = wrf_async_s'(SYNC_RESET);
  logic wdtRestartReq = 1'b0;
  logic [7:0] rdata;
  logic wdtResetPulse;
  logic chipResetReq;
  int n_mismatch = 0;
  int n_compared = 0;
  int pulseCnt = 0;
  logic [31:0] seed = 32'hf9dfb896;
  logic [FLAG_COUNT-1:0] mFlags;
  logic mWde;
  logic [2:0] mPresc;
  int mWin;
  wrf_async_s s1;
  wrf_async_s s2;
  logic rdPend;
  logic [7:0] rdExp;
  logic prevPulse;

  always #12.5 clk_sys = ~clk_sys;

  wrf_watchdog_top #(.DIV(TDIV), .BASE_TICKS(TBASE)) dut (
    .clk_sys(clk_sys),
    .rst(rst),
    .busReq(busReq),
    .rdata(rdata),
    .asyncIn(asyncIn),
    .wdtRestartReq(wdtRestartReq),
    .wdtResetPulse(wdtResetPulse),
    .chipResetReq(chipResetReq)
  );

  // ****************************************
  // Compare tasks
  // ****************************************
  task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk8

  task automatic chkRange(input int n, input int lo, input int hi);
    n_compared++;
    if (n < lo || n > hi) begin
      n_mismatch++;
      $display("ERROR at %0t: time-out after %0d cycles, exp %0d..%0d", $time, n, lo, hi);
    end
  endtask : chkRange

  task automatic end_sim;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  // ****************************************
  // Reference model
  // ****************************************
  always @(posedge clk_sys or posedge rst) begin : model
    logic chip;
    logic open;
    logic [FLAG_COUNT-1:0] fl;
    if (rst) begin
      mFlags <= CAUSE_RESET;
      mWde <= 1'b0;
      mPresc <= 3'h0;
      mWin <= 0;
      s1 <= wrf_async_s'(SYNC_RESET);
      s2 <= wrf_async_s'(SYNC_RESET);
      rdPend <= 1'b0;
      prevPulse <= 1'b0;
    end else begin
      chip = wdtResetPulse | ~s2.extReset_n | s2.brownoutReset | s2.testPortReset;
      chk8(rdata, rdPend ? rdExp : 8'h00, "read data");
      chk8({7'h0, chipResetReq}, {7'h0, chip}, "chip reset");
      chk8({7'h0, wdtResetPulse & prevPulse}, 8'h00, "pulse length");
      prevPulse <= wdtResetPulse;
      if (wdtResetPulse === 1'b1) pulseCnt++;
      rdPend <= busReq.rd;
      case (busReq.addr)
        ADDR_RESET_CAUSE: rdExp <= {3'h0, mFlags};
        ADDR_WDT_CTRL: rdExp <= {3'h0, mWin > 0, mWde | s2.alwaysOnFuse, mPresc};
        default: rdExp <= 8'h00;
      endcase
      s1 <= asyncIn;
      s2 <= s1;
      fl = mFlags;
      if (busReq.wr && busReq.addr == ADDR_RESET_CAUSE) fl = fl & busReq.wdata[4:0];
      fl = fl | {s2.testPortReset, wdtResetPulse, s2.brownoutReset, ~s2.extReset_n, 1'b0};
      mFlags <= fl;
      open = mWin > 0;
      if (chip) begin
        mWde <= 1'b0;
        mPresc <= 3'h0;
        mWin <= 0;
      end else if (busReq.wr && busReq.addr == ADDR_WDT_CTRL) begin
        if (busReq.wdata[3]) mWde <= 1'b1;
        else if (open) mWde <= 1'b0;
        if (open) mPresc <= busReq.wdata[2:0];
        mWin <= (busReq.wdata[4] & busReq.wdata[3]) ? 4 : (open ? mWin - 1 : 0);
      end else begin
        mWin <= open ? mWin - 1 : 0;
      end
    end
  end

  // ****************************************
  // Drivers
  // ****************************************
  task automatic op(input logic w, input logic r, input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    busReq <= '{wr: w, rd: r, addr: a, wdata: d};
  endtask : op

  task automatic idle(input int n);
    repeat (n) op(1'b0, 1'b0, 2'h0, 8'h00);
  endtask : idle

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    op(1'b1, 1'b0, a, d);
  endtask : wr

  task automatic rd(input logic [1:0] a);
    op(1'b0, 1'b1, a, 8'h00);
  endtask : rd

  task automatic doReset;
    @(posedge clk_sys);
    busReq <= '0;
    rst <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
  endtask : doReset

  task automatic restartPulse;
    @(posedge clk_sys);
    wdtRestartReq <= 1'b1;
    @(posedge clk_sys);
    wdtRestartReq <= 1'b0;
  endtask : restartPulse

  task automatic timeout(input int p);
    int n;
    int t;
    t = (TBASE * TDIV) << p;
    n = 0;
    while (wdtResetPulse !== 1'b1 && n < t + 20) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chkRange(n, t - TDIV - 3, t + TDIV + 3);
  endtask : timeout

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin : main
    int c;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (300) begin
      seed = xorshift(seed);
      wdtRestartReq <= seed[30];
      if (seed[1:0] == 2'h1) rd(seed[9:8]);
      else if (seed[1:0] == 2'h2) wr(seed[9:8], seed[23:16]);
      else idle(1);
    end
    wdtRestartReq <= 1'b1;
    doReset();
    rd(ADDR_RESET_CAUSE);
    rd(ADDR_WDT_CTRL);
    wr(ADDR_RESET_CAUSE, 8'hff);
    rd(ADDR_RESET_CAUSE);
    wr(ADDR_RESET_CAUSE, 8'h00);
    rd(ADDR_RESET_CAUSE);
    wr(ADDR_WDT_CTRL, 8'h08);
    rd(ADDR_WDT_CTRL);
    wr(ADDR_WDT_CTRL, 8'h00);
    wr(ADDR_WDT_CTRL, 8'h0f);
    rd(ADDR_WDT_CTRL);
    wr(ADDR_WDT_CTRL, 8'h18);
    repeat (5) rd(ADDR_WDT_CTRL);
    wr(ADDR_WDT_CTRL, 8'h18);
    wr(ADDR_WDT_CTRL, 8'h00);
    rd(ADDR_WDT_CTRL);
    wdtRestartReq <= 1'b0;
    for (int p = 0; p < 3; p++) begin
      wr(ADDR_WDT_CTRL, 8'h18);
      wr(ADDR_WDT_CTRL, 8'h08 | p[7:0]);
      idle(1);
      timeout(p);
      idle(1);
      rd(ADDR_RESET_CAUSE);
    end
    c = pulseCnt;
    wr(ADDR_WDT_CTRL, 8'h08);
    repeat (10) begin
      idle(3);
      restartPulse();
    end
    wr(ADDR_WDT_CTRL, 8'h18);
    wr(ADDR_WDT_CTRL, 8'h00);
    idle(100);
    chk8(pulseCnt[7:0], c[7:0], "pulse count");
    for (int i = 0; i < 3; i++) begin
      idle(1);
      asyncIn <= wrf_async_s'(SYNC_RESET ^ (4'h2 << i));
      idle(4);
      asyncIn <= wrf_async_s'(SYNC_RESET);
      idle(4);
      rd(ADDR_RESET_CAUSE);
    end
    asyncIn <= wrf_async_s'(SYNC_RESET | 4'h1);
    wdtRestartReq <= 1'b1;
    idle(4);
    rd(ADDR_WDT_CTRL);
    wr(ADDR_WDT_CTRL, 8'h18);
    wr(ADDR_WDT_CTRL, 8'h00);
    rd(ADDR_WDT_CTRL);
    restartPulse();
    timeout(0);
    idle(2);
    asyncIn <= wrf_async_s'(SYNC_RESET);
    idle(4);
    doReset();
    idle(1);
    rd(ADDR_RESET_CAUSE);
    idle(4);
    end_sim();
  end

  initial begin : watchdog
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    end_sim();
  end
endmodule : tb_wrf_watchdog_top
